// ### hw/cssc_top.sv
// Configurable stage stepper control: registers, stepper, crank hold
`timescale 1ns/1ps
`include "cssc_defines.svh"
module cssc_top
#(
   parameter int unsigned HOLD_CYCLES = `CSSC_HOLD_CYC
)
(
   input  wire logic       sys_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic       supply_reset_n_i,
   output logic      [7:0] rdata_o,
   output logic            br1_hs_a_o,
   output logic            br1_ls_a_o,
   output logic            br1_hs_b_o,
   output logic            br1_ls_b_o,
   output logic            br2_hs_a_o,
   output logic            br2_hs_b_o,
   output logic            br2_ls_a_o,
   output logic            br2_ls_b_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Next position in either direction
   function automatic cssc_pkg::cssc_pos_t step_pos(
      input cssc_pkg::cssc_pos_t pos,
      input logic                dir
   );
      cssc_pkg::cssc_pos_t r;
      r = pos;
      case (pos)
         cssc_pkg::POS_1: r = dir ? cssc_pkg::POS_2 : cssc_pkg::POS_4;
         cssc_pkg::POS_2: r = dir ? cssc_pkg::POS_3 : cssc_pkg::POS_1;
         cssc_pkg::POS_3: r = dir ? cssc_pkg::POS_4 : cssc_pkg::POS_2;
         cssc_pkg::POS_4: r = dir ? cssc_pkg::POS_1 : cssc_pkg::POS_3;
         default:         r = cssc_pkg::POS_1;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Supply reset synchroniser
   // ----------------------------------------
   logic        srst_meta;
   logic        srst_sync;
   logic        srst_prev;

   // Pin comes from another domain: two flops first
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         srst_meta <= 1'b1;
         srst_sync <= 1'b1;
         srst_prev <= 1'b1;
      end
      else
      begin
         srst_meta <= supply_reset_n_i;
         srst_sync <= srst_meta;
         srst_prev <= srst_sync;
      end
   end

   logic        srst_fall;
   assign srst_fall = srst_prev & ~srst_sync;

   // ----------------------------------------
   // Register file and stepper
   // ----------------------------------------
   logic                motor_en;
   logic                motor_dir;
   logic                motor_strobe;
   logic                arr_sel;
   logic                pair1;
   logic                pair2;
   logic [7:0]          stage;
   logic [1:0]          hold_en;
   cssc_pkg::cssc_pos_t pos;
   logic                hold_run;
   logic [15:0]         hold_cnt;
   logic                resumed;
   logic                next_motor_en;
   logic                next_motor_dir;
   logic                next_motor_strobe;
   logic                next_arr_sel;
   logic                next_pair1;
   logic                next_pair2;
   logic [7:0]          next_stage;
   logic [1:0]          next_hold_en;
   cssc_pkg::cssc_pos_t next_pos;
   logic                next_hold_run;
   logic [15:0]         next_hold_cnt;
   logic                next_resumed;
   logic                wr_motor;
   logic                wr_stage;
   logic                new_en;
   logic                new_strobe;

   assign wr_motor   = wr_i && (addr_i == `CSSC_MOTOR_OFS);
   assign wr_stage   = wr_i && (addr_i == `CSSC_STAGE_OFS);
   assign new_en     = wdata_i[`CSSC_EN_BIT];
   assign new_strobe = wdata_i[`CSSC_STROBE_BIT];

   // Register writes, stepping and crank hold timing
   always_comb
   begin
      next_motor_en     = motor_en;
      next_motor_dir    = motor_dir;
      next_motor_strobe = motor_strobe;
      next_arr_sel      = arr_sel;
      next_pair1        = pair1;
      next_pair2        = pair2;
      next_stage        = stage;
      next_hold_en      = hold_en;
      next_pos          = pos;
      next_hold_run     = hold_run;
      next_hold_cnt     = hold_cnt;
      next_resumed      = resumed;
      if (wr_motor)
      begin
         next_motor_en  = new_en;
         next_motor_dir = wdata_i[`CSSC_DIR_BIT];
         // Enable change in the frame swallows the strobe
         if (new_en == motor_en)
         begin
            next_motor_strobe = new_strobe;
            // Edge found against the stored strobe; old dir used
            if (motor_en && !motor_strobe && new_strobe)
               next_pos = step_pos(pos, motor_dir);
         end
      end
      if (wr_i && (addr_i == `CSSC_ARRANGE_OFS))
      begin
         next_arr_sel = wdata_i[`CSSC_ARR_BIT];
         next_pair1   = wdata_i[`CSSC_PAIR1_BIT];
         next_pair2   = wdata_i[`CSSC_PAIR2_BIT];
      end
      if (wr_i && (addr_i == `CSSC_CONF7_OFS))
         next_hold_en = wdata_i[1:0];
      // Stage bits go straight out; pairs are not cross-checked
      if (wr_stage)
         next_stage = wdata_i;
      // Hold window opens at the supply reset falling edge
      if (srst_fall && (hold_en != 2'h0))
      begin
         next_hold_run = 1'b1;
         next_hold_cnt = 16'h0000;
         next_resumed  = 1'b0;
      end
      else if (hold_run)
      begin
         if (wr_stage)
            next_resumed = 1'b1;
         if (hold_cnt >= 16'(HOLD_CYCLES - 1))
         begin
            next_hold_run = 1'b0;
            // Controller never came back: drop the held stages
            if (!(resumed || wr_stage))
            begin
               if (hold_en[`CSSC_HOLD_A_BIT])
                  next_stage[`CSSC_HS1A_IDX] = 1'b0;
               if (hold_en[`CSSC_HOLD_B_BIT])
                  next_stage[`CSSC_HS2A_IDX] = 1'b0;
            end
         end
         else
            next_hold_cnt = hold_cnt + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         motor_en     <= 1'(`CSSC_MOTOR_RST >> `CSSC_EN_BIT);
         motor_dir    <= 1'(`CSSC_MOTOR_RST >> `CSSC_DIR_BIT);
         motor_strobe <= 1'(`CSSC_MOTOR_RST >> `CSSC_STROBE_BIT);
         arr_sel      <= 1'(`CSSC_ARRANGE_RST >> `CSSC_ARR_BIT);
         pair1        <= 1'(`CSSC_ARRANGE_RST >> `CSSC_PAIR1_BIT);
         pair2        <= 1'(`CSSC_ARRANGE_RST >> `CSSC_PAIR2_BIT);
         stage        <= `CSSC_STAGE_RST;
         hold_en      <= `CSSC_CONF7_RST;
         pos          <= cssc_pkg::POS_1;
         hold_run     <= 1'b0;
         hold_cnt     <= 16'h0000;
         resumed      <= 1'b0;
      end
      else
      begin
         motor_en     <= next_motor_en;
         motor_dir    <= next_motor_dir;
         motor_strobe <= next_motor_strobe;
         arr_sel      <= next_arr_sel;
         pair1        <= next_pair1;
         pair2        <= next_pair2;
         stage        <= next_stage;
         hold_en      <= next_hold_en;
         pos          <= next_pos;
         hold_run     <= next_hold_run;
         hold_cnt     <= next_hold_cnt;
         resumed      <= next_resumed;
      end
   end

   // ----------------------------------------
   // Stage drive
   // ----------------------------------------
   logic       bridge_mode;
   logic       ph1;
   logic       ph2;
   logic [7:0] drive;
   logic [7:0] next_drive;

   // Crank-hold enables outrank the arrangement bit
   assign bridge_mode = !arr_sel && (hold_en == 2'h0);
   // Phase 0 of bridge one: hs_a+ls_b; of bridge two: hs_b+ls_a
   assign ph1 = pos[1];
   assign ph2 = pos[1] ^ pos[0];

   // Bridge mode drives both full bridges as a pair; otherwise the stage bits go out singly
   always_comb
   begin
      next_drive = stage;
      if (bridge_mode)
      begin
         next_drive = 8'h00;
         if (motor_en)
         begin
            next_drive[0] = !ph1;
            next_drive[3] = !ph1;
            next_drive[2] = ph1;
            next_drive[1] = ph1;
            next_drive[5] = !ph2;
            next_drive[6] = !ph2;
            next_drive[4] = ph2;
            next_drive[7] = ph2;
         end
         // Belt and braces: kill any same-leg overlap; diagonals are the legal pairs
         if (next_drive[0] && next_drive[1])
            next_drive[1:0] = 2'b00;
         if (next_drive[2] && next_drive[3])
            next_drive[3:2] = 2'b00;
         // Bridge two legs: hs_a with ls_a, hs_b with ls_b
         if (next_drive[4] && next_drive[6])
         begin
            next_drive[4] = 1'b0;
            next_drive[6] = 1'b0;
         end
         if (next_drive[5] && next_drive[7])
         begin
            next_drive[5] = 1'b0;
            next_drive[7] = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         drive <= 8'h00;
      else
         drive <= next_drive;
   end

   assign br1_hs_a_o = drive[0];
   assign br1_ls_a_o = drive[1];
   assign br1_hs_b_o = drive[2];
   assign br1_ls_b_o = drive[3];
   assign br2_hs_a_o = drive[4];
   assign br2_hs_b_o = drive[5];
   assign br2_ls_a_o = drive[6];
   assign br2_ls_b_o = drive[7];

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   logic [7:0] next_rdata;

   // Data only in the cycle after the strobe; zero otherwise
   always_comb
   begin
      next_rdata = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            `CSSC_MOTOR_OFS:   next_rdata = {5'h00, motor_strobe, motor_dir, motor_en};
            `CSSC_ARRANGE_OFS: next_rdata = {5'h00, pair2, pair1, arr_sel};
            `CSSC_STAGE_OFS:   next_rdata = stage;
            `CSSC_CONF7_OFS:   next_rdata = {6'h00, hold_en};
            `CSSC_STATUS_OFS:  next_rdata = {4'h0, resumed, hold_run, bridge_mode, 1'b0} |
                                            {6'h00, pos} << 4;
            default:           next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rdata_o <= 8'h00;
      else
         rdata_o <= next_rdata;
   end
endmodule

// ### hw/cssc_defines.svh
// Constants of the configurable stage stepper control block
// Functional notes
// - Four HS, four LS; bridge mode default
// - Individual mode allows paired low-side paralleling
// - Pair bits unchecked; controller writes both alike
// - Two HS stages held through crank dip
// - Crank hold enabled per stage, config seven
// - Any crank-hold enable forces individual mode
// - Enable low turns every bridge stage off
// - One step per strobe 0-to-1 write only
// - Direction one walks the forward sequence
// - Direction zero walks the reverse sequence
// - Power-on position is sequence state one
// - Never HS and LS of one half-bridge; only bridge mode enforces it, individual stage bits go out unchecked
// - Direction with strobe steps old direction
// - Enable with strobe ignores the strobe
// - Full H-bridge pairs in bridge mode, no half-bridges
// - Stages usable singly, same-type paralleling allowed
`ifndef CSSC_DEFINES_SVH
`define CSSC_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSSC_MOTOR_OFS    4'h0
`define CSSC_ARRANGE_OFS  4'h1
`define CSSC_STAGE_OFS    4'h2
`define CSSC_CONF7_OFS    4'h7
`define CSSC_STATUS_OFS   4'h8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSSC_EN_BIT       0
`define CSSC_DIR_BIT      1
`define CSSC_STROBE_BIT   2
`define CSSC_ARR_BIT      0
`define CSSC_PAIR1_BIT    1
`define CSSC_PAIR2_BIT    2
`define CSSC_HOLD_A_BIT   0
`define CSSC_HOLD_B_BIT   1
`define CSSC_HS1A_IDX     0
`define CSSC_HS2A_IDX     4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSSC_MOTOR_RST    3'h0
`define CSSC_ARRANGE_RST  3'h0
`define CSSC_STAGE_RST    8'h00
`define CSSC_CONF7_RST    2'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CSSC_CLK_MHZ      10
`define CSSC_HOLD_US      1000
`define CSSC_HOLD_CYC     (`CSSC_HOLD_US * `CSSC_CLK_MHZ)
`endif

// ### hw/cssc_pkg.sv
// Types of the configurable stage stepper control block
package cssc_pkg;
   // Step positions in forward order
   typedef enum logic [1:0] {POS_1, POS_2, POS_3, POS_4} cssc_pos_t;
endpackage

// ### test/cssc_checker.sv
// Port assertions of the stepper stage control block
`timescale 1ns/1ps
module cssc_checker
#(
   parameter int unsigned HOLD_CYCLES = 20
)
(
   input wire logic       sys_clk_i,
   input wire logic       reset_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       supply_reset_n_i,
   input wire logic       br1_hs_a_o,
   input wire logic       br1_ls_a_o,
   input wire logic       br1_hs_b_o,
   input wire logic       br1_ls_b_o,
   input wire logic       br2_hs_a_o,
   input wire logic       br2_hs_b_o,
   input wire logic       br2_ls_a_o,
   input wire logic       br2_ls_b_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [7:0] o, stg, lp;
   logic [2:0] m;
   logic [1:0] hold;
   logic       en, dir, stb, arr, sup, br, w0, go, br_d1, br_d2;
   // Outputs gathered in stage-register bit order
   assign o = {br2_ls_b_o, br2_ls_a_o, br2_hs_b_o, br2_hs_a_o,
               br1_ls_b_o, br1_hs_b_o, br1_ls_a_o, br1_hs_a_o};
   assign br = !arr && hold == 2'h0;
   assign m  = {sup, hold != 2'h0, arr};
   assign w0 = wr_i && addr_i == 4'h0 && br;
   assign go = w0 && en && wdata_i[0] && wdata_i[2] && !stb;
   // Next drive pattern of the step sequence
   function automatic logic [7:0] nx(input logic d, input logic [7:0] p);
      case (p)
         8'h69:   nx = d ? 8'h99 : 8'h66;
         8'h99:   nx = d ? 8'h96 : 8'h69;
         8'h96:   nx = d ? 8'h66 : 8'h99;
         default: nx = d ? 8'h69 : 8'h96;
      endcase
   endfunction
   // Shadow of the written bits; supply dip is sticky since hold timing is not modelled
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         {en, dir, stb, arr, hold, stg, sup} <= '0;
         {br_d1, br_d2} <= 2'b00;
         lp <= 8'h69;
      end
      else
      begin
         if (!supply_reset_n_i) sup <= 1'b1;
         // Bridge mode history kept in flops, not sampled-value calls
         br_d1 <= br;
         br_d2 <= br_d1;
         if (br && br_d1 && br_d2 && o != 8'h00) lp <= o;
         if (wr_i && addr_i == 4'h0)
         begin
            en  <= wdata_i[0];
            dir <= wdata_i[1];
            if (wdata_i[0] == en) stb <= wdata_i[2];
         end
         if (wr_i && addr_i == 4'h1) arr <= wdata_i[0];
         if (wr_i && addr_i == 4'h2) stg <= wdata_i;
         if (wr_i && addr_i == 4'h7) hold <= wdata_i[1:0];
      end
   end
   property p_overlap;
      br && $past(br) && $past(br, 2) |-> !(o[0] && o[1]) && !(o[2] && o[3])
         && !(o[4] && o[6]) && !(o[5] && o[7]);
   endproperty
   a_overlap: assert property (p_overlap) else $error("leg overlap");
   property p_off;
      w0 && !wdata_i[0] |-> ##2 o == 8'h00;
   endproperty
   a_off: assert property (p_off) else $error("bridge not off");
   property p_keep;
      w0 && en && wdata_i[0] && !wdata_i[2] |-> ##2 $stable(o);
   endproperty
   a_keep: assert property (p_keep) else $error("moved without strobe");
   property p_fwd;
      go && dir && wdata_i[1] |-> ##2 o == nx(1'b1, $past(o));
   endproperty
   a_fwd: assert property (p_fwd) else $error("bad forward step");
   property p_rev;
      go && !dir && !wdata_i[1] |-> ##2 o == nx(1'b0, $past(o));
   endproperty
   a_rev: assert property (p_rev) else $error("bad reverse step");
   property p_old_dir;
      go && dir != wdata_i[1] |-> ##2 o == nx($past(dir, 2), $past(o));
   endproperty
   a_old_dir: assert property (p_old_dir) else $error("new dir used");
   property p_en_strobe;
      w0 && !en && wdata_i[0] && wdata_i[2] |-> ##2 o == lp;
   endproperty
   a_en_strobe: assert property (p_en_strobe) else $error("strobe taken");
   property p_single;
      m == 3'h1 && m == $past(m) && m == $past(m, 2) |-> o == $past(stg);
   endproperty
   a_single: assert property (p_single) else $error("stage drive");
   property p_override;
      m == 3'h2 && m == $past(m) && m == $past(m, 2) |-> o == $past(stg);
   endproperty
   a_override: assert property (p_override) else $error("hold override");
   c_step:  cover property (go);
   c_dip:   cover property (!supply_reset_n_i);
   c_ind:   cover property (m == 3'h1);
endmodule
bind cssc_top cssc_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_cssc_checker (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .supply_reset_n_i(supply_reset_n_i),
   .br1_hs_a_o(br1_hs_a_o), .br1_ls_a_o(br1_ls_a_o), .br1_hs_b_o(br1_hs_b_o),
   .br1_ls_b_o(br1_ls_b_o), .br2_hs_a_o(br2_hs_a_o), .br2_hs_b_o(br2_hs_b_o),
   .br2_ls_a_o(br2_ls_a_o), .br2_ls_b_o(br2_ls_b_o));

// ### test/cssc_mcu_model.sv
// Controller model: register frames and the supply reset pin
`timescale 1ns/1ps
module cssc_mcu_model
(
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [3:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic            supply_reset_n_o
);
   // Idle bus at time zero
   initial
   begin
      {addr_o, wdata_o, wr_o, rd_o} = '0;
      supply_reset_n_o = 1'b1;
   end
   // One-cycle write; released data shows the inverse so stale bits never match
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask
   // Read; data taken at the edge closing the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      rd_o   <= 1'b0;
      @(posedge sys_clk_i);
      d = rdata_i;
   endtask
   // Crank dip: controller held in reset for a few cycles
   task automatic crank();
      @(posedge sys_clk_i);
      supply_reset_n_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      supply_reset_n_o <= 1'b1;
   endtask
endmodule

// ### test/cssc_top_bench.sv
// Self-checking bench of the stepper stage control block
`timescale 1ns/1ps
module cssc_top_bench;
   logic       sys_clk_i, reset_n_i, wr, rd, sup_n;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, rv;
   wire  [7:0] o;
   int         bad_count, compares, seed, en, dir, stb, pos, arr, hold, stg;
   int         pat [4] = '{8'h69, 8'h99, 8'h96, 8'h66};
   // Short hold window keeps the run brief
   cssc_top #(.HOLD_CYCLES(20)) u_cssc_top (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .supply_reset_n_i(sup_n), .rdata_o(rdata),
      .br1_hs_a_o(o[0]), .br1_ls_a_o(o[1]), .br1_hs_b_o(o[2]), .br1_ls_b_o(o[3]),
      .br2_hs_a_o(o[4]), .br2_hs_b_o(o[5]), .br2_ls_a_o(o[6]), .br2_ls_b_o(o[7]));
   cssc_mcu_model u_cssc_mcu_model (
      .sys_clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .supply_reset_n_o(sup_n));
   // Clock and watchdog
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      #200_000;
      bad_count++;
      finish_test();
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      compares++;
      if (got !== want)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Reference drive from the shadow state
   function automatic logic [7:0] expect_o();
      if (arr != 0 || hold != 0) return stg[7:0];
      return (en != 0) ? pat[pos][7:0] : 8'h00;
   endfunction
   // Write a frame, update the reference, compare once the drive has settled
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      if (a == 4'h0)
      begin
         // Position steps in any arrangement; only the drive depends on it
         if (en != 0 && d[0] && d[2] && stb == 0)
            pos = (pos + ((dir != 0) ? 1 : 3)) % 4;
         if (d[0] == en) stb = d[2];
         en  = d[0];
         dir = d[1];
      end
      if (a == 4'h1) arr = d[0];
      if (a == 4'h2) stg = d;
      if (a == 4'h7) hold = d[1:0];
      u_cssc_mcu_model.wr_reg(a, d);
      repeat (2) @(posedge sys_clk_i);
      #1 chk(o, expect_o());
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      seed = 32'h34ba_3ef3;
      {en, dir, stb, pos, arr, hold, stg} = '0;
      reset_n_i = 1'b0;
      repeat (8) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      u_cssc_mcu_model.rd_reg(4'h3, rv);
      chk(rv, 8'h00);
      u_cssc_mcu_model.rd_reg(4'h8, rv);
      chk(rv & 8'h32, 8'h02);
      put(4'h0, 8'h05);
      put(4'h5, 8'hff);
      // Random motor frames, direction and enable often mixed with the strobe
      repeat (60) put(4'h0, 8'($random(seed)) & 8'h07);
      u_cssc_mcu_model.rd_reg(4'h0, rv);
      chk(rv, 8'(stb * 4 + dir * 2 + en));
      u_cssc_mcu_model.rd_reg(4'h8, rv);
      chk(rv & 8'h30, 8'(pos * 16));
      put(4'h1, 8'h07);
      repeat (20)
      begin
         rv    = 8'($random(seed));
         rv[3] = rv[1];
         rv[7] = rv[6];
         put(4'h2, rv);
      end
      put(4'h1, 8'h00);
      put(4'h2, 8'h11);
      put(4'h7, 8'h01);
      u_cssc_mcu_model.rd_reg(4'h8, rv);
      chk(rv & 8'h02, 8'h00);
      // Dip without resume: only the enabled stage drops at expiry
      u_cssc_mcu_model.crank();
      repeat (11) @(posedge sys_clk_i);
      #1 chk(o, 8'h11);
      repeat (15) @(posedge sys_clk_i);
      stg = 8'h10;
      #1 chk(o, 8'h10);
      u_cssc_mcu_model.rd_reg(4'h2, rv);
      chk(rv, 8'h10);
      u_cssc_mcu_model.rd_reg(4'h7, rv);
      chk(rv, 8'h01);
      put(4'h7, 8'h03);
      put(4'h2, 8'h11);
      // Dip with resume inside the window keeps both stages
      u_cssc_mcu_model.crank();
      put(4'h2, 8'h11);
      repeat (40) @(posedge sys_clk_i);
      #1 chk(o, 8'h11);
      finish_test();
   end
endmodule
